/* File: core/mdw_pkg.sv */
// Function
// R1: wait at least 200 us after power-up before any cycle
// R2: then issue eight row-strobe cycles with transfer enable high and eight shift clocks
// R3: with the internal refresh counter, use eight column-before-row cycles instead
// R4: write enable low before column strobe makes an early write, outputs stay off
// R5: write enable late after row, column strobe and address gives read-modify-write
// R6: neither timing means undefined output; never rely on it
// R7: address may change at most twice while row strobe is low
// R8: address may change at most once while row low and column high
// R9: byte enable low at row fall latches mask; function level picks masked write kind
// R10: byte enables high at row fall: function levels pick normal, block or color load
// R11: mask bit low blocks that bit, high lets it be written
// R12: in block write each four data pins mask four adjacent columns
// R13: a byte enable low at row fall turns on write-per-bit masking
// R14: write-per-bit writes only unmasked positions and keeps the rest
// R15: block and flash writes store the color register under the masks
package mdw_pkg;
   localparam int CLK_MHZ = 25;
   localparam int CLK_NS = 40;
   localparam int PAUSE_US = 200;
   localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
   localparam int T_RWD_NS = 90;
   localparam int T_CWD_NS = 40;
   localparam int T_AWD_NS = 55;
   localparam int RWD_CYC = (T_RWD_NS + CLK_NS - 1) / CLK_NS;
   localparam int CWD_CYC = (T_CWD_NS + CLK_NS - 1) / CLK_NS;
   localparam int AWD_CYC = (T_AWD_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_ACC_CYC = 2;
   localparam int SYNC_CYC = 2;
   localparam int LATE_A = (RWD_CYC > 2) ? RWD_CYC - 2 : 1;
   localparam int LATE_B = (CWD_CYC > LATE_A) ? CWD_CYC : LATE_A;
   localparam int LATE_C = (AWD_CYC > LATE_B) ? AWD_CYC : LATE_B;
   localparam int LATE_D = READ_ACC_CYC + SYNC_CYC;
   localparam logic [3:0] CAS_RD_CYC = 4'((LATE_D > LATE_C) ? LATE_D : LATE_C);
   localparam logic [3:0] RAS_MIN_CYC = 4'h3;
   localparam logic [3:0] PRE_CYC = 4'h2;
   localparam logic [3:0] INIT_CNT = 4'h8;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h1;
   localparam logic [3:0] REG_ROW = 4'h2;
   localparam logic [3:0] REG_COL = 4'h3;
   localparam logic [3:0] REG_DATA = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h5;
   localparam logic [3:0] REG_BYTE = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_RDATA = 4'h8;
   localparam int CTRL_GO = 0;
   localparam int CTRL_CBR = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_INIT_DONE = 1;
   localparam int ST_RVALID = 2;
   localparam int ST_REFUSED = 3;
   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_WRITE = 3'h1,
      OP_MASKED_WRITE = 3'h2,
      OP_BLOCK = 3'h3,
      OP_MASKED_BLOCK = 3'h4,
      OP_MASKED_FLASH = 3'h5,
      OP_LOAD_COLOR = 3'h6,
      OP_RMW = 3'h7
   } mdw_op_e;
   typedef struct packed {
      logic sfsel_ras;
      logic mask_ras;
      logic sfsel_cas;
      logic wr;
      logic late;
   } mdw_mode_s;
endpackage

/* File: core/mdw_init_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mdw_init_if;
   logic go;
   logic ack;
   logic req;
   logic req_shift;
   logic done;
   modport seq (input go, input ack, output req, output req_shift, output done);
   modport ctl (output go, output ack, input req, input req_shift, input done);
endinterface
`default_nettype wire

/* File: core/mdw_init.sv */
`timescale 1ns/1ps
`default_nettype none
module mdw_init #(
   parameter int PAUSE_CYC = mdw_pkg::PAUSE_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   mdw_init_if.seq ini
);
   import mdw_pkg::*;
   typedef enum logic [4:0] {
      I_PAUSE = 5'b00001,
      I_WAIT_GO = 5'b00010,
      I_RAS = 5'b00100,
      I_SHIFT = 5'b01000,
      I_DONE = 5'b10000
   } mdw_ist_e;
   typedef struct packed {
      mdw_ist_e st;
      logic [15:0] cnt;
      logic req;
      logic req_shift;
      logic done;
   } mdw_iseq_s;
   mdw_iseq_s s;
   mdw_iseq_s n;
   assign ini.req = s.req;
   assign ini.req_shift = s.req_shift;
   assign ini.done = s.done;
   always_comb begin
      n = s;
      unique case (s.st)
         I_PAUSE: begin
            // R1
            if (s.cnt == 16'(PAUSE_CYC - 1)) begin
               n.st = I_WAIT_GO;
               n.cnt = 16'h0000;
            end else begin
               n.cnt = s.cnt + 16'h0001;
            end
         end
         I_WAIT_GO: begin
            if (ini.go) begin
               n.st = I_RAS;
               n.req = 1'b1;
            end
         end
         I_RAS: begin
            // R2 R3
            if (ini.ack) begin
               if (s.cnt == 16'(INIT_CNT - 4'h1)) begin
                  n.st = I_SHIFT;
                  n.cnt = 16'h0000;
                  n.req_shift = 1'b1;
               end else begin
                  n.cnt = s.cnt + 16'h0001;
               end
            end
         end
         I_SHIFT: begin
            // R2
            if (ini.ack) begin
               if (s.cnt == 16'(INIT_CNT - 4'h1)) begin
                  n.st = I_DONE;
                  n.req = 1'b0;
                  n.req_shift = 1'b0;
                  n.done = 1'b1;
               end else begin
                  n.cnt = s.cnt + 16'h0001;
               end
            end
         end
         I_DONE: begin
            n.done = 1'b1;
         end
         default: begin
            n.st = I_PAUSE;
         end
      endcase
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s <= '{st: I_PAUSE, cnt: 16'h0000, req: 1'b0, req_shift: 1'b0, done: 1'b0};
      end else begin
         s <= n;
      end
   end
endmodule
`default_nettype wire

/* File: core/mdw_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module mdw_ctrl #(
   parameter int PAUSE_CYC = mdw_pkg::PAUSE_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic ras_n,
   output logic cas_n,
   output logic [8:0] dram_addr,
   output logic [15:0] dq_o,
   input wire logic [15:0] dq_i,
   output logic dq_oe,
   output logic write_enable_low_byte_n,
   output logic write_enable_high_byte_n,
   output logic special_function_select,
   output logic transfer_output_enable_n,
   output logic shift_clock_pin
);
   import mdw_pkg::*;
   typedef enum logic [7:0] {
      S_IDLE = 8'b00000001,
      S_CBR = 8'b00000010,
      S_ROW = 8'b00000100,
      S_COL = 8'b00001000,
      S_CAS = 8'b00010000,
      S_LATE = 8'b00100000,
      S_PRE = 8'b01000000,
      S_SHIFT = 8'b10000000
   } mdw_st_e;
   typedef struct packed {
      mdw_st_e st;
      logic [3:0] wait_cnt;
      logic init_cyc;
      logic ack;
      mdw_op_e op;
      logic ras_n;
      logic cas_n;
      logic [8:0] addr;
      logic [15:0] dq_o;
      logic dq_oe;
      logic we_lo_n;
      logic we_hi_n;
      logic sfsel;
      logic toe_n;
      logic shclk;
      logic init_go;
      logic use_cbr;
      logic [8:0] row;
      logic [8:0] col;
      logic [15:0] data;
      logic [15:0] mask;
      logic [1:0] byte_en;
      logic [15:0] rdata;
      logic rvalid;
      logic refused;
      logic [15:0] rd_data;
      logic [15:0] dq_s1;
      logic [15:0] dq_s2;
   } mdw_ctrl_s;
   mdw_ctrl_s s;
   mdw_ctrl_s n;
   mdw_mode_s m;
   mdw_op_e cmd_op;
   mdw_init_if ini ();
   mdw_init #(.PAUSE_CYC(PAUSE_CYC)) u_init (
      .clk_sys(clk_sys),
      .reset(reset),
      .ini(ini)
   );
   assign ini.go = s.init_go;
   assign ini.ack = s.ack;
   // pin levels per write kind
   function automatic mdw_mode_s op_mode(input mdw_op_e op);
      mdw_mode_s r;
      r = '{sfsel_ras: 1'b0, mask_ras: 1'b0, sfsel_cas: 1'b0, wr: 1'b1, late: 1'b0};
      unique case (op)
         OP_READ: r.wr = 1'b0;
         OP_WRITE: r.sfsel_cas = 1'b0; // R10
         OP_MASKED_WRITE: r.mask_ras = 1'b1; // R9 R13
         OP_BLOCK: r.sfsel_cas = 1'b1; // R10 R12
         OP_MASKED_BLOCK: begin
            r.mask_ras = 1'b1; // R9
            r.sfsel_cas = 1'b1;
         end
         OP_MASKED_FLASH: begin
            r.mask_ras = 1'b1; // R9 R15
            r.sfsel_ras = 1'b1;
         end
         OP_LOAD_COLOR: begin
            r.sfsel_ras = 1'b1; // R10
            r.sfsel_cas = 1'b1;
         end
         OP_RMW: begin
            r.wr = 1'b0;
            r.late = 1'b1;
         end
      endcase
      return r;
   endfunction
   // close the cycle: strobes high, bus released
   function automatic mdw_ctrl_s enter_pre(input mdw_ctrl_s x);
      mdw_ctrl_s r;
      r = x;
      r.st = S_PRE;
      r.ras_n = 1'b1;
      r.cas_n = 1'b1;
      r.we_lo_n = 1'b1;
      r.we_hi_n = 1'b1;
      r.dq_oe = 1'b0;
      r.toe_n = 1'b1;
      r.sfsel = 1'b0;
      r.wait_cnt = PRE_CYC - 4'h1;
      return r;
   endfunction
   assign cmd_op = mdw_op_e'(reg_wdata[2:0]);
   assign m = op_mode(s.op);
   always_comb begin
      n = s;
      n.ack = 1'b0;
      n.rd_data = 16'h0000;
      n.dq_s1 = dq_i;
      n.dq_s2 = s.dq_s1;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: n.rd_data = {14'h0000, s.use_cbr, s.init_go};
            REG_ROW: n.rd_data = {7'h00, s.row};
            REG_COL: n.rd_data = {7'h00, s.col};
            REG_DATA: n.rd_data = s.data;
            REG_MASK: n.rd_data = s.mask;
            REG_BYTE: n.rd_data = {14'h0000, s.byte_en};
            REG_STATUS: begin
               n.rd_data = {12'h000, s.refused, s.rvalid, ini.done, s.st != S_IDLE};
               n.refused = 1'b0;
            end
            REG_RDATA: n.rd_data = s.rdata;
            default: n.rd_data = 16'h0000;
         endcase
      end
      if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL: begin
               n.init_go = reg_wdata[CTRL_GO];
               n.use_cbr = reg_wdata[CTRL_CBR];
            end
            REG_ROW: n.row = reg_wdata[8:0];
            REG_COL: n.col = reg_wdata[8:0];
            REG_DATA: n.data = reg_wdata;
            REG_MASK: n.mask = reg_wdata;
            REG_BYTE: n.byte_en = reg_wdata[1:0];
            default: n.init_go = s.init_go;
         endcase
      end
      if (reg_wr && reg_addr == REG_CMD && (s.st != S_IDLE || !ini.done)) begin
         n.refused = 1'b1;
      end
      unique case (s.st)
         S_IDLE: begin
            if (!ini.done) begin
               // R1 R2 R3
               if (ini.req && !s.ack) begin
                  n.init_cyc = 1'b1;
                  n.toe_n = 1'b1;
                  n.addr = 9'h000;
                  if (ini.req_shift) begin
                     n.st = S_SHIFT;
                     n.shclk = 1'b1;
                  end else if (s.use_cbr) begin
                     n.st = S_CBR;
                     n.cas_n = 1'b0;
                  end else begin
                     n.st = S_ROW;
                     n.ras_n = 1'b0;
                     n.wait_cnt = RAS_MIN_CYC - 4'h1;
                  end
               end
            end else if (reg_wr && reg_addr == REG_CMD) begin
               n.op = cmd_op;
               n.st = S_ROW;
               n.rvalid = 1'b0;
               n.ras_n = 1'b0;
               n.addr = s.row;
               n.toe_n = 1'b1;
               n.sfsel = op_mode(cmd_op).sfsel_ras; // R9 R10
               n.we_lo_n = ~op_mode(cmd_op).mask_ras; // R13
               n.we_hi_n = ~op_mode(cmd_op).mask_ras;
               n.dq_o = s.mask; // R11 R14
               n.dq_oe = op_mode(cmd_op).mask_ras;
               n.wait_cnt = 4'h0;
            end
         end
         S_CBR: begin
            n.st = S_ROW;
            n.ras_n = 1'b0;
            n.wait_cnt = RAS_MIN_CYC - 4'h1;
         end
         S_ROW: begin
            if (s.init_cyc) begin
               if (s.wait_cnt != 4'h0) begin
                  n.wait_cnt = s.wait_cnt - 4'h1;
               end else begin
                  n = enter_pre(n);
               end
            end else begin
               // single row-to-column address change
               n.st = S_COL; // R7 R8
               n.addr = s.col;
               n.sfsel = m.sfsel_cas; // R9 R10
               if (m.wr) begin
                  // R4
                  n.we_lo_n = ~s.byte_en[0];
                  n.we_hi_n = ~s.byte_en[1];
                  n.dq_o = s.data; // R12 R15
                  n.dq_oe = 1'b1;
               end else begin
                  n.we_lo_n = 1'b1;
                  n.we_hi_n = 1'b1;
                  n.dq_oe = 1'b0;
                  n.toe_n = 1'b0;
               end
            end
         end
         S_COL: begin
            n.st = S_CAS;
            n.cas_n = 1'b0;
            n.wait_cnt = m.wr ? 4'h0 : CAS_RD_CYC - 4'h1;
         end
         S_CAS: begin
            if (s.wait_cnt != 4'h0) begin
               n.wait_cnt = s.wait_cnt - 4'h1;
            end else if (!m.wr) begin
               // R5 R6
               n.rdata = s.dq_s2;
               n.rvalid = 1'b1;
               if (m.late) begin
                  n.st = S_LATE;
                  n.toe_n = 1'b1;
                  n.wait_cnt = 4'h1;
               end else begin
                  n = enter_pre(n);
               end
            end else begin
               n = enter_pre(n);
            end
         end
         S_LATE: begin
            // outputs turned off a cycle before data is driven
            if (s.wait_cnt != 4'h0) begin
               n.wait_cnt = 4'h0;
               n.we_lo_n = ~s.byte_en[0]; // R5
               n.we_hi_n = ~s.byte_en[1];
               n.dq_o = s.data;
               n.dq_oe = 1'b1;
            end else begin
               n = enter_pre(n);
            end
         end
         S_PRE: begin
            if (s.wait_cnt != 4'h0) begin
               n.wait_cnt = s.wait_cnt - 4'h1;
            end else begin
               n.st = S_IDLE;
               n.ack = s.init_cyc;
               n.init_cyc = 1'b0;
            end
         end
         S_SHIFT: begin
            n.shclk = 1'b0; // R2
            n.st = S_IDLE;
            n.ack = 1'b1;
            n.init_cyc = 1'b0;
         end
         default: begin
            n = enter_pre(n);
         end
      endcase
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s <= '{st: S_IDLE, wait_cnt: 4'h0, init_cyc: 1'b0, ack: 1'b0, op: OP_READ,
                ras_n: 1'b1, cas_n: 1'b1, addr: 9'h000, dq_o: 16'h0000, dq_oe: 1'b0,
                we_lo_n: 1'b1, we_hi_n: 1'b1, sfsel: 1'b0, toe_n: 1'b1, shclk: 1'b0,
                init_go: 1'b0, use_cbr: 1'b0, row: 9'h000, col: 9'h000,
                data: 16'h0000, mask: 16'h0000, byte_en: 2'h3, rdata: 16'h0000,
                rvalid: 1'b0, refused: 1'b0, rd_data: 16'h0000,
                dq_s1: 16'h0000, dq_s2: 16'h0000};
      end else begin
         s <= n;
      end
   end
   assign reg_rdata = s.rd_data;
   assign ras_n = s.ras_n;
   assign cas_n = s.cas_n;
   assign dram_addr = s.addr;
   assign dq_o = s.dq_o;
   assign dq_oe = s.dq_oe;
   assign write_enable_low_byte_n = s.we_lo_n;
   assign write_enable_high_byte_n = s.we_hi_n;
   assign special_function_select = s.sfsel;
   assign transfer_output_enable_n = s.toe_n;
   assign shift_clock_pin = s.shclk;
endmodule
`default_nettype wire

/* File: tb/mdw_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module mdw_dev (
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic [8:0] a,
   input wire logic [15:0] dq,
   input wire logic we_lo_n,
   input wire logic we_hi_n,
   input wire logic sfs,
   input wire logic toe_n,
   output logic [15:0] dq_drv
);
   logic [15:0] mem [16];
   logic [15:0] color;
   logic [15:0] wmask;
   logic [15:0] bm;
   logic sf_row;
   logic msk_row;
   logic [3:0] col;
   function automatic void put(input logic [3:0] i, input logic [15:0] d, input logic [15:0] m);
      mem[i] = (mem[i] & ~m) | (d & m);
   endfunction
   // pins settle one step after the controller's edge
   always begin
      @(negedge ras_n);
      #1;
      sf_row = sfs;
      msk_row = !we_lo_n || !we_hi_n;
      wmask = msk_row ? dq : 16'hFFFF;
   end
   always begin
      @(negedge cas_n);
      #1;
      col = a[3:0];
      bm = wmask & {{8{!we_hi_n}}, {8{!we_lo_n}}};
      if (!ras_n && !(we_lo_n && we_hi_n)) begin
         if (sf_row && msk_row) begin
            for (int i = 0; i < 16; i++) put(4'(i), color, bm);
         end else if (sf_row) begin
            color = dq;
         end else if (sfs) begin
            for (int i = 0; i < 4; i++) begin
               put({col[3:2], 2'(i)}, color,
                   bm & {{4{dq[12+i]}}, {4{dq[8+i]}}, {4{dq[4+i]}}, {4{dq[i]}}});
            end
         end else begin
            put(col, dq, bm);
         end
      end
   end
   always begin
      @(negedge we_lo_n or negedge we_hi_n);
      #1;
      if (!ras_n && !cas_n) put(col, dq, wmask & {{8{!we_hi_n}}, {8{!we_lo_n}}});
   end
   // released pins show the inverse
   assign dq_drv = (!ras_n && !cas_n && !toe_n && we_lo_n && we_hi_n) ? mem[col] : ~mem[col];
endmodule
`default_nettype wire

/* File: tb/mdw_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mdw_ctrl_chk #(
   parameter int PAUSE_CYC = 20
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic [8:0] dram_addr,
   input wire logic dq_oe,
   input wire logic write_enable_low_byte_n,
   input wire logic write_enable_high_byte_n,
   input wire logic transfer_output_enable_n,
   input wire logic shift_clock_pin
);
   int up;
   logic [3:0] rf;
   logic [3:0] scn;
   logic [2:0] ch2;
   logic [2:0] ch1;
   wire logic we_off = write_enable_low_byte_n & write_enable_high_byte_n;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         up <= 0;
         rf <= 4'h0;
         scn <= 4'h0;
         ch2 <= 3'h0;
         ch1 <= 3'h0;
      end else begin
         if (up < PAUSE_CYC) up <= up + 1;
         if ($fell(ras_n) && rf != 4'hF) rf <= rf + 4'h1;
         if ($rose(shift_clock_pin) && scn != 4'hF) scn <= scn + 4'h1;
         if (ras_n) begin
            ch2 <= 3'h0;
            ch1 <= 3'h0;
         end else if ($changed(dram_addr) && !$past(ras_n)) begin
            ch2 <= ch2 + 3'h1;
            if (cas_n && $past(cas_n)) ch1 <= ch1 + 3'h1;
         end
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   property p_pause; $fell(ras_n) |-> up >= PAUSE_CYC - 1; endproperty
   a_pause: assert property (p_pause) else $error("row strobe in pause");
   property p_trg; $fell(ras_n) |-> transfer_output_enable_n; endproperty
   a_trg: assert property (p_trg) else $error("transfer enable low at row fall");
   property p_sc; $rose(shift_clock_pin) |-> rf == 4'h8 ##1 !shift_clock_pin; endproperty
   a_sc: assert property (p_sc) else $error("shift clock misplaced");
   property p_ops; $fell(ras_n) && rf >= 4'h8 |-> scn == 4'h8; endproperty
   a_ops: assert property (p_ops) else $error("access before init");
   property p_cbr; $fell(cas_n) && ras_n |=> $fell(ras_n) && rf < 4'h8; endproperty
   a_cbr: assert property (p_cbr) else $error("bad refresh cycle");
   property p_twice; !ras_n |-> ch2 <= 3'h2; endproperty
   a_twice: assert property (p_twice) else $error("address moved thrice");
   property p_once; !ras_n |-> ch1 <= 3'h1; endproperty
   a_once: assert property (p_once) else $error("address moved twice");
   property p_free;
      !transfer_output_enable_n && !cas_n && !ras_n && we_off |-> !dq_oe;
   endproperty
   a_free: assert property (p_free) else $error("data contention");
   property p_early; $fell(cas_n) && dq_oe |-> transfer_output_enable_n && !ras_n; endproperty
   a_early: assert property (p_early) else $error("write not early");
   property p_mask; $fell(ras_n) && !we_off |-> dq_oe; endproperty
   a_mask: assert property (p_mask) else $error("mask not driven");
endmodule
bind mdw_ctrl mdw_ctrl_chk #(.PAUSE_CYC(PAUSE_CYC)) mdw_ctrl_chk_inst (
   .clk_sys(clk_sys), .reset(reset), .ras_n(ras_n), .cas_n(cas_n), .dram_addr(dram_addr),
   .dq_oe(dq_oe), .write_enable_low_byte_n(write_enable_low_byte_n),
   .write_enable_high_byte_n(write_enable_high_byte_n),
   .transfer_output_enable_n(transfer_output_enable_n), .shift_clock_pin(shift_clock_pin)
);
`default_nettype wire

/* File: tb/multiport_dram_write_mode_decode_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module multiport_dram_write_mode_decode_bench;
   import mdw_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic want = 1'b0;
   logic want_d = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic [15:0] reg_rdata, dq_o, dq_i, dq_drv, v, old, color;
   logic [15:0] emem [16];
   logic [15:0] exp_q [$];
   logic ras_n, cas_n, dq_oe, wl_n, wh_n, sfs, toe_n, sclk;
   logic [8:0] dram_addr;
   logic [8:0] c;
   logic [2:0] o;
   logic [2:0] ops [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   int failures = 0;
   int check_count = 0;
   int rf, scn, cbrn;
   assign dq_i = dq_oe ? dq_o : dq_drv;
   mdw_ctrl #(.PAUSE_CYC(20)) mdw_ctrl_inst (
      .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ras_n(ras_n), .cas_n(cas_n),
      .dram_addr(dram_addr), .dq_o(dq_o), .dq_i(dq_i), .dq_oe(dq_oe),
      .write_enable_low_byte_n(wl_n), .write_enable_high_byte_n(wh_n),
      .special_function_select(sfs), .transfer_output_enable_n(toe_n), .shift_clock_pin(sclk)
   );
   mdw_dev mdw_dev_inst (
      .ras_n(ras_n), .cas_n(cas_n), .a(dram_addr), .dq(dq_i), .we_lo_n(wl_n), .we_hi_n(wh_n),
      .sfs(sfs), .toe_n(toe_n), .dq_drv(dq_drv)
   );
   initial forever #20 clk_sys = ~clk_sys;
   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   function automatic void put(input logic [3:0] i, input logic [15:0] d, input logic [15:0] m);
      emem[i] = (emem[i] & ~m) | (d & m);
   endfunction
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // w low: plain poll, value left in v
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic w);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      want <= w;
      if (w) exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wt(input int n, input logic val);
      int i;
      for (i = 0; i < 300; i++) begin
         rd(REG_STATUS, 16'h0, 1'b0);
         if (v[n] === val) break;
      end
      ck("status wait", 16'(val), 16'(v[n]));
   endtask
   task automatic op(input logic [2:0] o, input logic [8:0] c, input logic [15:0] d,
                     input logic [15:0] m, input logic [1:0] b);
      logic [15:0] bm;
      bm = {{8{b[1]}}, {8{b[0]}}} & ((o == 3'h2 || o == 3'h4 || o == 3'h5) ? m : 16'hFFFF);
      wr(REG_COL, {7'h0, c});
      wr(REG_DATA, d);
      wr(REG_MASK, m);
      wr(REG_BYTE, {14'h0, b});
      rd(REG_COL, {7'h0, c}, 1'b1);
      rd(REG_DATA, d, 1'b1);
      rd(REG_MASK, m, 1'b1);
      wr(REG_CMD, {13'h0, o});
      wt(ST_BUSY, 1'b0);
      if (o == 3'h6) color = d;
      if (o == 3'h5) for (int i = 0; i < 16; i++) put(4'(i), color, bm);
      if (o == 3'h3 || o == 3'h4) begin
         for (int i = 0; i < 4; i++) begin
            put({c[3:2], 2'(i)}, color,
                bm & {{4{d[12+i]}}, {4{d[8+i]}}, {4{d[4+i]}}, {4{d[i]}}});
         end
      end
      if (o == 3'h1 || o == 3'h2 || o == 3'h7) put(c[3:0], d, bm);
   endtask
   always @(posedge clk_sys) begin
      want_d <= reg_rd && want;
      if (want_d) ck("reg_rdata", exp_q.pop_front(), reg_rdata);
   end
   always @(negedge ras_n) begin
      rf++;
      if (!cas_n) cbrn++;
   end
   always @(posedge sclk) scn++;
   initial begin
      repeat (30000) @(posedge clk_sys);
      failures++;
      print_verdict();
   end
   initial begin
      void'($urandom(39814));
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_sys);
         reset <= 1'b1;
         repeat (8) @(posedge clk_sys);
         reset <= 1'b0;
         rf = 0;
         scn = 0;
         cbrn = 0;
         rd(REG_BYTE, 16'h0003, 1'b1);
         rd(4'hF, 16'h0000, 1'b1);
         wr(REG_CMD, 16'h0001);
         rd(REG_STATUS, 16'h0008, 1'b1);
         rd(REG_STATUS, 16'h0000, 1'b1);
         c = 9'($urandom);
         wr(REG_ROW, {7'h0, c});
         rd(REG_ROW, {7'h0, c}, 1'b1);
         wr(REG_CTRL, {14'h0, p[0], 1'b1});
         rd(REG_CTRL, {14'h0, p[0], 1'b1}, 1'b1);
         wt(ST_INIT_DONE, 1'b1);
         ck("row cycles", 16'h0008, 16'(rf));
         ck("shift clocks", 16'h0008, 16'(scn));
         ck("refresh cycles", p[0] ? 16'h0008 : 16'h0000, 16'(cbrn));
         op(3'h6, 9'h0, 16'($urandom), 16'h0, 2'h3);
         op(3'h5, 9'h0, 16'h0, 16'hFFFF, 2'h3);
         for (int k = 0; k < 10; k++) begin
            c = 9'($urandom);
            o = ops[$urandom % 5];
            old = emem[c[3:0]];
            op(o, c, 16'($urandom), 16'($urandom), 2'($urandom));
            if (o == 3'h7) rd(REG_RDATA, old, 1'b1);
         end
         wr(REG_CMD, 16'h0000);
         wr(REG_CMD, 16'h0000);
         rd(REG_STATUS, 16'h0, 1'b0);
         ck("refused", 16'h000B, v & 16'h000B);
         wt(ST_BUSY, 1'b0);
         for (int k = 0; k < 16; k++) begin
            op(3'h0, 9'(k), 16'h0, 16'h0, 2'h0);
            rd(REG_RDATA, emem[k], 1'b1);
         end
      end
      print_verdict();
   end
endmodule
`default_nettype wire
